//--- core/shared_pin_port_control.v
// How it works
// R1: select bits on misc pins pick functional signal at 0, port at 1.
// R2: sensor clock direction field 00 makes the pin an input.
// R3: field 01 makes the pin an output at 12 mA strength.
// R4: field 10 makes the pin an output at 24 mA strength.
// R5: software must never write 11 to a field of an output pin.
// R6: sensor clock functional output only when field is 01 or 10.
// R7: single direction bits on misc pins: 0 input, 1 output.
// R8: misc functional output appears only while direction bit is 1; aux_pin_4/5 have no direction bit and always drive.
// R9: port mode output drives the last value written to the level register.
// R10: level register reads return live sampled pin levels.
// R11: aux_pin_4 and aux_pin_5 level bits read back the stored value.
// R12: port_level_a holds sensor_clock_6..2 at 12-8, 1e..1a at 4-0.
// R13: dir_select_a holds 1a..1e fields in bit pairs 1:0 up to 9:8.
// R14: dir_select_b holds 2..6 fields in bit pairs 1:0 up to 9:8.
// R15: port_select_a resets all sensor pins to port, 0 function, 1 port.
// R16: reserved bits ignore writes and read as zero.
`timescale 1ns/1ps
`include "pin_port_defs.vh"
module shared_pin_port_control #(
   parameter ADDR_W = 7
) (
   input wire clk,
   input wire rst_n,
   input wire reg_wr,
   input wire reg_rd,
   input wire [ADDR_W-1:0] reg_addr,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata,
   output reg reg_rvalid,
   input wire [15:0] sensor_func,
   input wire [15:0] misc_func,
   input wire [15:0] sensor_pin_in,
   input wire [15:0] misc_pin_in,
   output reg [15:0] sensor_pin_out,
   output reg [15:0] sensor_pin_oe,
   output reg [15:0] sensor_pin_strong,
   output reg [15:0] sensor_pin_fault,
   output reg [15:0] misc_pin_out,
   output reg [15:0] misc_pin_oe
);
   reg [15:0] port_select_a_q;
   reg [15:0] port_select_b_q;
   reg [15:0] dir_select_a_q;
   reg [15:0] dir_select_b_q;
   reg [15:0] dir_select_c_q;
   reg [15:0] port_level_a_q;
   reg [15:0] port_level_b_q;
   reg [15:0] sens_meta_q;
   reg [15:0] sens_sync_q;
   reg [15:0] misc_meta_q;
   reg [15:0] misc_sync_q;
   reg [15:0] rdata_d;
   reg [15:0] sens_out_d;
   reg [15:0] sens_oe_d;
   reg [15:0] sens_strong_d;
   reg [15:0] sens_fault_d;
   reg [15:0] misc_out_d;
   reg [15:0] misc_oe_d;
   reg [1:0] field;
   integer i;
   integer j;
   integer k;
   integer m;
   // R16: reserved bits are masked off on every write
   wire we_port_select_a;
   wire we_port_select_b;
   wire we_dir_select_a;
   wire we_dir_select_b;
   wire we_dir_select_c;
   wire we_port_level_a;
   wire we_port_level_b;
   assign we_port_select_a = reg_wr && (reg_addr == `ADDR_PORT_SELECT_A);
   assign we_port_select_b = reg_wr && (reg_addr == `ADDR_PORT_SELECT_B);
   assign we_dir_select_a = reg_wr && (reg_addr == `ADDR_DIR_SELECT_A);
   assign we_dir_select_b = reg_wr && (reg_addr == `ADDR_DIR_SELECT_B);
   assign we_dir_select_c = reg_wr && (reg_addr == `ADDR_DIR_SELECT_C);
   assign we_port_level_a = reg_wr && (reg_addr == `ADDR_PORT_LEVEL_A);
   assign we_port_level_b = reg_wr && (reg_addr == `ADDR_PORT_LEVEL_B);

   // maps a sensor pin bit position to its direction field
   function [1:0] dir_field;
      input integer pos;
      input [15:0] dir_a;
      input [15:0] dir_b;
      begin
         if (pos < `SENSOR_B_BASE) begin
            dir_field = dir_a[2*pos +: 2];
         end else begin
            dir_field = dir_b[2*(pos-`SENSOR_B_BASE) +: 2];
         end
      end
   endfunction

   // tells whether a bit position is implemented in a mask
   function mask_bit;
      input integer pos;
      input [15:0] mask;
      begin
         mask_bit = mask[pos];
      end
   endfunction

   // merges live levels with the stored aux_pin_4/aux_pin_5 bits
   function [15:0] level_b_view;
      input [15:0] pins;
      input [15:0] stored;
      begin
         level_b_view = pins & `MASK_SELECT_B;
         level_b_view[`BIT_AUX_4] = stored[`BIT_AUX_4];
         level_b_view[`BIT_AUX_5] = stored[`BIT_AUX_5];
      end
   endfunction

   // two-flop synchroniser on sensor pin levels
   always @(posedge clk) begin
      if (!rst_n) begin
         sens_meta_q <= 16'h0000;
         sens_sync_q <= 16'h0000;
      end else begin
         sens_meta_q <= sensor_pin_in;
         sens_sync_q <= sens_meta_q;
      end
   end

   // two-flop synchroniser on misc pin levels
   always @(posedge clk) begin
      if (!rst_n) begin
         misc_meta_q <= 16'h0000;
         misc_sync_q <= 16'h0000;
      end else begin
         misc_meta_q <= misc_pin_in;
         misc_sync_q <= misc_meta_q;
      end
   end

   // R15: sensor pins start in port mode
   always @(posedge clk) begin
      if (!rst_n) begin
         port_select_a_q <= `RST_PORT_SELECT_A;
      end else if (we_port_select_a) begin
         port_select_a_q <= reg_wdata & `MASK_SENSOR;
      end
   end

   // R1: misc pin select register
   always @(posedge clk) begin
      if (!rst_n) begin
         port_select_b_q <= `RST_PORT_SELECT_B;
      end else if (we_port_select_b) begin
         port_select_b_q <= reg_wdata & `MASK_SELECT_B;
      end
   end

   // R13: first direction register layout
   always @(posedge clk) begin
      if (!rst_n) begin
         dir_select_a_q <= `RST_DIR;
      end else if (we_dir_select_a) begin
         dir_select_a_q <= reg_wdata & `MASK_DIR_AB;
      end
   end

   // R14: second direction register layout
   always @(posedge clk) begin
      if (!rst_n) begin
         dir_select_b_q <= `RST_DIR;
      end else if (we_dir_select_b) begin
         dir_select_b_q <= reg_wdata & `MASK_DIR_AB;
      end
   end

   // R7: misc direction bits
   always @(posedge clk) begin
      if (!rst_n) begin
         dir_select_c_q <= `RST_DIR;
      end else if (we_dir_select_c) begin
         dir_select_c_q <= reg_wdata & `MASK_DIR_C;
      end
   end

   // R12: sensor level bit layout
   always @(posedge clk) begin
      if (!rst_n) begin
         port_level_a_q <= `RST_LEVEL;
      end else if (we_port_level_a) begin
         port_level_a_q <= reg_wdata & `MASK_SENSOR;
      end
   end

   // R9: stored levels kept even while the pin is an input
   always @(posedge clk) begin
      if (!rst_n) begin
         port_level_b_q <= `RST_LEVEL;
      end else if (we_port_level_b) begin
         port_level_b_q <= reg_wdata & `MASK_SELECT_B;
      end
   end

   // read mux; a write in the same cycle is seen only by the next read
   always @* begin
      rdata_d = 16'h0000;
      case (reg_addr)
         `ADDR_PORT_SELECT_A: begin
            rdata_d = port_select_a_q;
         end
         `ADDR_PORT_SELECT_B: begin
            rdata_d = port_select_b_q;
         end
         `ADDR_DIR_SELECT_A: begin
            rdata_d = dir_select_a_q;
         end
         `ADDR_DIR_SELECT_B: begin
            rdata_d = dir_select_b_q;
         end
         `ADDR_DIR_SELECT_C: begin
            rdata_d = dir_select_c_q;
         end
         // R10: live pin levels
         `ADDR_PORT_LEVEL_A: begin
            rdata_d = sens_sync_q & `MASK_SENSOR;
         end
         // R11: aux 4 and 5 return stored value
         `ADDR_PORT_LEVEL_B: begin
            rdata_d = level_b_view(misc_sync_q, port_level_b_q);
         end
         default: begin
            rdata_d = 16'h0000;
         end
      endcase
   end

   // direction decode for sensor clock pins
   always @* begin
      sens_oe_d = 16'h0000;
      sens_strong_d = 16'h0000;
      sens_fault_d = 16'h0000;
      field = `DIR_INPUT;
      for (i = 0; i < `PIN_COUNT; i = i + 1) begin
         field = dir_field(i, dir_select_a_q, dir_select_b_q);
         if (mask_bit(i, `MASK_SENSOR)) begin
            // R2: input; R3 and R4: output strengths; R6: only 01/10 drive
            case (field)
               `DIR_OUT_12MA: begin
                  sens_oe_d[i] = 1'b1;
               end
               `DIR_OUT_24MA: begin
                  sens_oe_d[i] = 1'b1;
                  sens_strong_d[i] = 1'b1;
               end
               // R5: forbidden code held off the pin and flagged
               `DIR_FORBIDDEN: begin
                  sens_fault_d[i] = 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // R9: port level when in port mode; R1 style select
   always @* begin
      sens_out_d = 16'h0000;
      for (j = 0; j < `PIN_COUNT; j = j + 1) begin
         if (mask_bit(j, `MASK_SENSOR)) begin
            sens_out_d[j] = port_select_a_q[j] ? port_level_a_q[j] : sensor_func[j];
         end
      end
   end

   // R1: select picks port or function
   always @* begin
      misc_out_d = 16'h0000;
      for (k = 0; k < `PIN_COUNT; k = k + 1) begin
         if (mask_bit(k, `MASK_SELECT_B)) begin
            misc_out_d[k] = port_select_b_q[k] ? port_level_b_q[k] : misc_func[k];
         end
      end
   end

   // R7: direction bit; R8: function only while it is 1
   always @* begin
      misc_oe_d = 16'h0000;
      for (m = 0; m < `PIN_COUNT; m = m + 1) begin
         if (mask_bit(m, `MASK_DIR_C)) begin
            misc_oe_d[m] = dir_select_c_q[m];
         end else if (mask_bit(m, `MASK_SELECT_B)) begin
            // aux_pin_4/5 are output-only pins
            misc_oe_d[m] = 1'b1;
         end
      end
   end

   // read data stands one cycle and is zero otherwise
   always @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= reg_rd ? rdata_d : 16'h0000;
      end
   end

   // read answer one cycle after the strobe
   always @(posedge clk) begin
      if (!rst_n) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
      end
   end

   // sensor pin level register
   always @(posedge clk) begin
      if (!rst_n) begin
         sensor_pin_out <= 16'h0000;
      end else begin
         sensor_pin_out <= sens_out_d;
      end
   end

   // sensor pin enable and strength registers
   always @(posedge clk) begin
      if (!rst_n) begin
         sensor_pin_oe <= 16'h0000;
         sensor_pin_strong <= 16'h0000;
      end else begin
         sensor_pin_oe <= sens_oe_d;
         sensor_pin_strong <= sens_strong_d;
      end
   end

   // flag lets software see a forbidden field that is held off the pin
   always @(posedge clk) begin
      if (!rst_n) begin
         sensor_pin_fault <= 16'h0000;
      end else begin
         sensor_pin_fault <= sens_fault_d;
      end
   end

   // misc pin level register
   always @(posedge clk) begin
      if (!rst_n) begin
         misc_pin_out <= 16'h0000;
      end else begin
         misc_pin_out <= misc_out_d;
      end
   end

   // misc pin enable register
   always @(posedge clk) begin
      if (!rst_n) begin
         misc_pin_oe <= 16'h0000;
      end else begin
         misc_pin_oe <= misc_oe_d;
      end
   end

endmodule // shared_pin_port_control

//--- core/pin_port_defs.vh
`ifndef PIN_PORT_DEFS_VH
`define PIN_PORT_DEFS_VH
// register addresses on the host register port
`define ADDR_PORT_SELECT_A 7'h59
`define ADDR_PORT_SELECT_B 7'h5A
`define ADDR_DIR_SELECT_A 7'h5B
`define ADDR_DIR_SELECT_B 7'h5C
`define ADDR_DIR_SELECT_C 7'h5D
`define ADDR_PORT_LEVEL_A 7'h5E
`define ADDR_PORT_LEVEL_B 7'h5F
// reset values
`define RST_PORT_SELECT_A 16'h1F1F
`define RST_PORT_SELECT_B 16'hF0FF
`define RST_DIR 16'h0000
`define RST_LEVEL 16'h0000
// implemented-bit masks
`define MASK_SENSOR 16'h1F1F
`define MASK_SELECT_B 16'hF0FF
`define MASK_DIR_AB 16'h03FF
`define MASK_DIR_C 16'hF03F
// direction field codes
`define DIR_INPUT 2'b00
`define DIR_OUT_12MA 2'b01
`define DIR_OUT_24MA 2'b10
`define DIR_FORBIDDEN 2'b11
// positions of the level-stored aux pins in port_level_b
`define BIT_AUX_4 6
`define BIT_AUX_5 7
// pin vector width and first sensor bit held in the second direction register
`define PIN_COUNT 16
`define SENSOR_B_BASE 8
`endif

//--- dv/pin_port_props.sv
`timescale 1ns/1ps
module pin_port_props #(parameter ADDR_W = 7) (
   input wire clk, rst_n, reg_wr, reg_rd, reg_rvalid,
   input wire [ADDR_W-1:0] reg_addr,
   input wire [15:0] reg_wdata, reg_rdata, sensor_func, misc_func, sensor_pin_in,
   input wire [15:0] misc_pin_in, sensor_pin_out, sensor_pin_oe, sensor_pin_strong,
   input wire [15:0] sensor_pin_fault, misc_pin_out, misc_pin_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   read_answer_a: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   unmapped_read_a: assert property (reg_rd && reg_addr > 7'h5F |=> reg_rdata == 0)
      else $error("unmapped read not zero");
   level_rsvd_a: assert property (reg_rd && reg_addr == 7'h5E |=> !(reg_rdata & ~16'h1F1F))
      else $error("reserved level bits set");
   dir_field_a: assert property (reg_wr && reg_addr == 7'h5B |-> ##2
      sensor_pin_oe[0] == ^$past(reg_wdata[1:0], 2)) else $error("field enable wrong");
   drive_strength_a: assert property (reg_wr && reg_addr == 7'h5C |-> ##2
      sensor_pin_strong[12] == ($past(reg_wdata[9:8], 2) == 2'b10)) else $error("strength wrong");
   misc_dir_a: assert property (reg_wr && reg_addr == 7'h5D |-> ##2
      (misc_pin_oe & 16'hF03F) == ($past(reg_wdata, 2) & 16'hF03F)) else $error("misc oe wrong");
   aux_out_a: assert property ($past(rst_n) |-> misc_pin_oe[11:6] == 6'h03)
      else $error("aux enable wrong");
   fault_off_a: assert property (!(sensor_pin_fault & sensor_pin_oe))
      else $error("faulty field drives");
   strong_oe_a: assert property (!(sensor_pin_strong & ~sensor_pin_oe))
      else $error("strength without drive");
   cover property (reg_rvalid && reg_rdata != 0);
   cover property (sensor_pin_strong != 0);
   cover property (sensor_pin_fault != 0);
   cover property (misc_pin_oe == 16'hF0FF);
endmodule // pin_port_props

//--- dv/pin_far_side.sv
`timescale 1ns/1ps
module pin_far_side (
   input wire [15:0] sensor_pin_out, sensor_pin_oe, misc_pin_out, misc_pin_oe, s_ext,
   output wire [15:0] sensor_pin_in, misc_pin_in
);
   assign sensor_pin_in = sensor_pin_out & sensor_pin_oe | s_ext & ~sensor_pin_oe;
   assign misc_pin_in = misc_pin_out & misc_pin_oe;
endmodule // pin_far_side

//--- dv/tb_shared_pin_port_control.sv
`timescale 1ns/1ps
module tb_shared_pin_port_control;
   logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, reg_rvalid;
   logic [6:0] reg_addr = 7'h00;
   logic [15:0] reg_wdata = 0, sensor_func = 0, misc_func = 0, s_ext = 0, reg_rdata;
   logic [15:0] sensor_pin_in, misc_pin_in, sensor_pin_out, sensor_pin_oe;
   logic [15:0] sensor_pin_strong, sensor_pin_fault, misc_pin_out, misc_pin_oe;
   logic [15:0] msk [7] = '{16'h1F1F, 16'hF0FF, 16'h03FF, 16'h03FF, 16'hF03F, 16'h1F1F, 16'hF0FF};
   int bad_count = 0, n_compared = 0;
   always #12.5 clk = ~clk;
   shared_pin_port_control dut_u (.*);
   pin_far_side far_u (.*);
   task stop_test;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rdc(input logic [6:0] a, input logic [15:0] e);
      int n;
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      for (n = 0; n < 3 && reg_rvalid !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      if (n == 3) begin
         bad_count++;
         stop_test;
      end
      chk(reg_rdata, e);
   endtask
   task settle;
      repeat (4) @(posedge clk);
      #1;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) rdc(7'(7'h59 + i), i == 1 ? 16'hF0FF : 16'h1F1F & msk[i] & {16{i == 0}});
      rdc(7'h60, 16'h0000);
      $display("reset values done");
      // alternating pattern keeps every direction field off the damaging code
      for (int i = 0; i < 7; i++) wr(7'(7'h59 + i), 16'hAAAA);
      for (int i = 0; i < 7; i++) rdc(7'(7'h59 + i), 16'hAAAA & msk[i]);
      $display("register access done");
      wr(7'h59, 16'h1F1F);
      wr(7'h5B, 16'h0155);
      wr(7'h5C, 16'h02AA);
      wr(7'h5E, 16'h1505);
      settle;
      chk(sensor_pin_oe, 16'h1F1F);
      chk(sensor_pin_strong, 16'h1F00);
      chk(sensor_pin_out & sensor_pin_oe, 16'h1505);
      @(posedge clk);
      s_ext <= 16'h001F;
      sensor_func <= 16'h0A0A;
      wr(7'h5B, 16'h0000);
      settle;
      chk(sensor_pin_oe, 16'h1F00);
      rdc(7'h5E, 16'h151F);
      wr(7'h59, 16'h0000);
      settle;
      chk(sensor_pin_out & sensor_pin_oe, 16'h0A00);
      wr(7'h5B, 16'h0003);
      settle;
      chk(sensor_pin_fault, 16'h0001);
      chk(sensor_pin_oe, 16'h1F00);
      $display("sensor pins done");
      @(posedge clk);
      misc_func <= 16'h5A5A;
      wr(7'h5A, 16'h0000);
      wr(7'h5D, 16'hF03F);
      wr(7'h5F, 16'h0080);
      settle;
      chk(misc_pin_oe, 16'hF0FF);
      chk(misc_pin_out & misc_pin_oe, 16'h505A);
      rdc(7'h5F, 16'h509A);
      wr(7'h5D, 16'h0000);
      settle;
      chk(misc_pin_oe, 16'h00C0);
      wr(7'h5D, 16'hF03F);
      wr(7'h5A, 16'hF0FF);
      settle;
      chk(misc_pin_out & misc_pin_oe, 16'h0080);
      rdc(7'h5F, 16'h0080);
      $display("misc pins done");
      stop_test;
   end
endmodule // tb_shared_pin_port_control
bind shared_pin_port_control pin_port_props #(.ADDR_W(ADDR_W)) props_u (.*);
